// ---- dcz_ctrl_port.sv ----
// Serial control port, mode registers and zero flag pins of the stereo converter.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - PCM zero after 1024 low word periods.
// - Bit stream balanced option flags zero after 23 ms of balanced bytes.
// - Bit stream fixed option flags zero after 23 ms of pattern 96h.
// - Each zero flag pin goes high for its own channel.
// - Port runs from its own bit clock and select, sampled through two-flop synchronisers on clk.
// - Readback enable turns left pin into read data, right pin into AND.
// - Each access is a 16-bit word; top bit 1 reads, 0 writes.
// - Bits 14..8 are the index, bits 7..0 the data.
// - Read data shifts out after the eighth bit clock completes.
// - Write lands only on the rising edge of the sixteenth bit clock.
// - Index 12h holds load enable, format, de-emphasis and soft mute.
// - Index 13h holds phase invert, attenuation rate and converter halt.
// - Index 13h also holds readback enable, stereo bypass, rolloff, zero mute.
// - Index 14h holds soft reset, bit stream mode and filter bypass.
// - Index 14h also holds single_channel_out output, channel pick and modulator rate.
// - Index 15h holds PCM zero enable and bit stream zero mode.
// - Index 17h is read-only five-bit part identifier.
// - Attenuation levels apply only while load enable is set.
module dcz_ctrl_port
   import dcz_pkg::*;
#(
   parameter logic [4:0] PART_ID = 5'h01, // Arbitrary value.
   parameter int WORD_COUNT = ZERO_WORDS,
   parameter int BS_CYCLES = BS_ZERO_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ctrl_bit_clock,
   input wire logic ctrl_select_n,
   input wire logic ctrl_serial_in,
   input wire logic lr_word_clock,
   input wire logic audio_bit_clock,
   input wire logic left_data_in,
   input wire logic right_data_in,
   output logic left_zero_flag_pin,
   output logic right_zero_flag_pin,
   output logic [7:0] left_atten_level,
   output logic [7:0] right_atten_level,
   output logic [7:0] format_ctrl,
   output logic [7:0] output_ctrl,
   output logic [7:0] mode_ctrl,
   output logic [7:0] zero_ctrl
);
   typedef struct packed {
      logic [1:0] mc_sync;
      logic [1:0] ms_sync;
      logic [1:0] mdi_sync;
      logic [1:0] wck_sync;
      logic [1:0] bck_sync;
      logic [1:0] dl_sync;
      logic [1:0] dr_sync;
      logic mc_prev;
      logic wck_prev;
      logic bck_prev;
      dcz_state_type state;
      logic [4:0] bitcnt;
      logic [15:0] shreg;
      logic reading;
      logic [7:0] rd_data;
      logic [5:0][7:0] regs;
      logic [7:0] atl_applied;
      logic [7:0] atr_applied;
      logic zl_pin;
      logic zr_pin;
   } dcz_top_type;

   dcz_top_type cur_ff, nxt;
   logic zero_l, zero_r;
   logic mc_rise, mc_fall, wck_edge, bck_rise;
   logic [7:0] rd_mux;
   logic [2:0] wr_slot;
   logic [6:0] idx;

   // --------------------------------------------------------------
   // Per-channel zero detectors
   // --------------------------------------------------------------
   dcz_zero_chan #(.WORD_COUNT(WORD_COUNT), .BS_CYCLES(BS_CYCLES)) u_zero_l (
      .clk(clk),
      .arst_n(arst_n),
      .word_tick(wck_edge),
      .data_tick(bck_rise),
      .data_bit(cur_ff.dl_sync[1]),
      .bs_mode(cur_ff.regs[4][BSM_BIT]),
      .dz_mode(cur_ff.regs[5][DZ_LSB+1:DZ_LSB]),
      .zero_ff(zero_l)
   );
   dcz_zero_chan #(.WORD_COUNT(WORD_COUNT), .BS_CYCLES(BS_CYCLES)) u_zero_r (
      .clk(clk),
      .arst_n(arst_n),
      .word_tick(wck_edge),
      .data_tick(bck_rise),
      .data_bit(cur_ff.dr_sync[1]),
      .bs_mode(cur_ff.regs[4][BSM_BIT]),
      .dz_mode(cur_ff.regs[5][DZ_LSB+1:DZ_LSB]),
      .zero_ff(zero_r)
   );

   // --------------------------------------------------------------
   // Edge detection on synchronised pins
   // --------------------------------------------------------------
   // Only the second stage feeds edges, so no logic sees a metastable bit.
   assign mc_rise = cur_ff.mc_sync[1] && !cur_ff.mc_prev;
   assign mc_fall = !cur_ff.mc_sync[1] && cur_ff.mc_prev;
   assign wck_edge = cur_ff.wck_sync[1] && !cur_ff.wck_prev;
   assign bck_rise = cur_ff.bck_sync[1] && !cur_ff.bck_prev;
   // The index sits low after eight bits but has moved up by the last bit of a write.
   assign idx = (cur_ff.bitcnt > READ_START_CNT) ? cur_ff.shreg[IDX_MSB-1:IDX_LSB-1] :
                cur_ff.shreg[IDX_MSB-IDX_LSB:0];

   // --------------------------------------------------------------
   // Read mux over the register file
   // --------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      wr_slot = 3'h7;
      if (idx >= IDX_LEFT_ATTEN && idx < IDX_ZERO_STATUS) begin
         wr_slot = 3'(idx - IDX_LEFT_ATTEN);
         rd_mux = cur_ff.regs[wr_slot];
      end else if (idx == IDX_ZERO_STATUS) begin
         rd_mux = {6'h00, zero_r, zero_l};
      end else if (idx == IDX_PART_ID) begin
         rd_mux = {3'h0, PART_ID};
      end
   end

   // --------------------------------------------------------------
   // Next state of the port and pins
   // --------------------------------------------------------------
   always_comb begin
      nxt = cur_ff;
      nxt.mc_sync = {cur_ff.mc_sync[0], ctrl_bit_clock};
      nxt.ms_sync = {cur_ff.ms_sync[0], ctrl_select_n};
      nxt.mdi_sync = {cur_ff.mdi_sync[0], ctrl_serial_in};
      nxt.wck_sync = {cur_ff.wck_sync[0], lr_word_clock};
      nxt.bck_sync = {cur_ff.bck_sync[0], audio_bit_clock};
      nxt.dl_sync = {cur_ff.dl_sync[0], left_data_in};
      nxt.dr_sync = {cur_ff.dr_sync[0], right_data_in};
      nxt.mc_prev = cur_ff.mc_sync[1];
      nxt.wck_prev = cur_ff.wck_sync[1];
      nxt.bck_prev = cur_ff.bck_sync[1];
      case (cur_ff.state)
         DCZ_IDLE: begin
            nxt.bitcnt = 5'h00;
            nxt.reading = 1'b0;
            nxt.rd_data = 8'h00;
            if (!cur_ff.ms_sync[1]) begin
               nxt.state = DCZ_SHIFT;
            end
         end
         DCZ_SHIFT: begin
            if (cur_ff.ms_sync[1]) begin
               nxt.state = DCZ_IDLE;
            end else if (mc_rise) begin
               nxt.shreg = {cur_ff.shreg[14:0], cur_ff.mdi_sync[1]};
               nxt.bitcnt = cur_ff.bitcnt + 5'h01;
               if (cur_ff.bitcnt == READ_START_CNT - 5'h01) begin
                  // Bit 15 is now at the top of the seven captured bits.
                  nxt.reading = cur_ff.shreg[6];
               end
               if (cur_ff.bitcnt == WORD_DONE_CNT - 5'h01) begin
                  nxt.state = DCZ_WAIT_HIGH;
                  if (!cur_ff.reading && wr_slot < RW_REG_COUNT) begin
                     nxt.regs[wr_slot] = {cur_ff.shreg[6:0], cur_ff.mdi_sync[1]};
                  end
               end
            end else if (mc_fall && cur_ff.bitcnt == READ_START_CNT) begin
               nxt.rd_data = rd_mux;
            end else if (mc_fall && cur_ff.reading && cur_ff.bitcnt > READ_START_CNT) begin
               nxt.rd_data = {cur_ff.rd_data[6:0], 1'b0};
            end
         end
         DCZ_WAIT_HIGH: begin
            // Extra clocks are ignored until select goes high again.
            if (cur_ff.ms_sync[1]) begin
               nxt.state = DCZ_IDLE;
            end
         end
         default: begin
            nxt.state = DCZ_IDLE;
         end
      endcase
      // Levels pass on only while the load enable is set.
      if (cur_ff.regs[2][ATTEN_LOAD_ENABLE_BIT]) begin
         nxt.atl_applied = cur_ff.regs[0];
         nxt.atr_applied = cur_ff.regs[1];
      end
      // A soft reset returns the mode registers to defaults.
      if (cur_ff.regs[4][SOFT_SYSTEM_RESET_BIT]) begin
         nxt.regs[0] = RST_LEFT_ATTEN;
         nxt.regs[1] = RST_RIGHT_ATTEN;
         nxt.regs[2] = RST_FORMAT_CTRL;
         nxt.regs[3] = RST_OUTPUT_CTRL;
         nxt.regs[4] = RST_MODE_CTRL;
         nxt.regs[5] = RST_ZERO_CTRL;
      end
      if (cur_ff.regs[3][READBACK_OUTPUT_ENABLE_BIT]) begin
         nxt.zl_pin = cur_ff.reading && cur_ff.bitcnt > READ_START_CNT - 5'h01 &&
                      cur_ff.state == DCZ_SHIFT && cur_ff.rd_data[DATA_MSB];
         nxt.zr_pin = zero_l && zero_r;
      end else if (cur_ff.regs[4][BSM_BIT] || cur_ff.regs[5][PCM_ZERO_OUT_ENABLE_BIT]) begin
         nxt.zl_pin = zero_l;
         nxt.zr_pin = zero_r;
      end else begin
         nxt.zl_pin = 1'b0;
         nxt.zr_pin = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= '0;
         cur_ff.ms_sync <= 2'h3;
         cur_ff.state <= DCZ_IDLE;
         cur_ff.regs[0] <= RST_LEFT_ATTEN;
         cur_ff.regs[1] <= RST_RIGHT_ATTEN;
         cur_ff.regs[2] <= RST_FORMAT_CTRL;
         cur_ff.regs[3] <= RST_OUTPUT_CTRL;
         cur_ff.regs[4] <= RST_MODE_CTRL;
         cur_ff.regs[5] <= RST_ZERO_CTRL;
         cur_ff.atl_applied <= RST_LEFT_ATTEN;
         cur_ff.atr_applied <= RST_RIGHT_ATTEN;
      end else begin
         cur_ff <= nxt;
      end
   end

   // --------------------------------------------------------------
   // Outputs straight from flip-flops
   // --------------------------------------------------------------
   assign left_zero_flag_pin = cur_ff.zl_pin;
   assign right_zero_flag_pin = cur_ff.zr_pin;
   assign left_atten_level = cur_ff.atl_applied;
   assign right_atten_level = cur_ff.atr_applied;
   assign format_ctrl = cur_ff.regs[2];
   assign output_ctrl = cur_ff.regs[3];
   assign mode_ctrl = cur_ff.regs[4];
   assign zero_ctrl = cur_ff.regs[5];
endmodule : dcz_ctrl_port
`default_nettype wire

// ---- dcz_pkg.sv ----
// Package of constants and types for the serial control port and zero detect block.
package dcz_pkg;
   // -----------------------------------------------------------------
   // Command word layout
   // -----------------------------------------------------------------
   localparam int CMD_BITS = 16;
   localparam int RW_BIT = 15;
   localparam int IDX_MSB = 14;
   localparam int IDX_LSB = 8;
   localparam int DATA_MSB = 7;
   localparam logic [4:0] READ_START_CNT = 5'h08;
   localparam logic [4:0] WORD_DONE_CNT = 5'h10;
   // -----------------------------------------------------------------
   // Register indices
   // -----------------------------------------------------------------
   localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
   localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
   localparam logic [6:0] IDX_FORMAT_CTRL = 7'h12;
   localparam logic [6:0] IDX_OUTPUT_CTRL = 7'h13;
   localparam logic [6:0] IDX_MODE_CTRL = 7'h14;
   localparam logic [6:0] IDX_ZERO_CTRL = 7'h15;
   localparam logic [6:0] IDX_ZERO_STATUS = 7'h16;
   localparam logic [6:0] IDX_PART_ID = 7'h17;
   localparam logic [2:0] RW_REG_COUNT = 3'h6;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_LEFT_ATTEN = 8'hFF;
   localparam logic [7:0] RST_RIGHT_ATTEN = 8'hFF;
   localparam logic [7:0] RST_FORMAT_CTRL = 8'h50;
   localparam logic [7:0] RST_OUTPUT_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE_CTRL = 8'h00;
   localparam logic [7:0] RST_ZERO_CTRL = 8'h01;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int ATTEN_LOAD_ENABLE_BIT = 7;
   localparam int MUTE_BIT = 0;
   localparam int REV_BIT = 7;
   localparam int OPE_BIT = 4;
   localparam int READBACK_OUTPUT_ENABLE_BIT = 3;
   localparam int BYPASS_STEREO_SEL_BIT = 2;
   localparam int FLT_BIT = 1;
   localparam int INFINITE_ZERO_MUTE_BIT = 0;
   localparam int SOFT_SYSTEM_RESET_BIT = 6;
   localparam int BSM_BIT = 5;
   localparam int FILTER_BYPASS_BIT = 4;
   localparam int SINGLE_CHANNEL_OUT_BIT = 3;
   localparam int SINGLE_CHANNEL_OUT_CHANNEL_PICK_BIT = 2;
   localparam int PCM_ZERO_OUT_ENABLE_BIT = 0;
   localparam int DZ_LSB = 1;
   // -----------------------------------------------------------------
   // Zero detect timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int ZERO_WORDS = 1024;
   localparam int BS_ZERO_MS = 23;
   localparam int BS_ZERO_CYCLES = (CLK_HZ / 1000) * BS_ZERO_MS;
   localparam logic [1:0] DZ_BALANCED = 2'h1;
   localparam logic [1:0] DZ_FIXED = 2'h2;
   localparam logic [7:0] FIXED_PATTERN = 8'h96;
   localparam logic [3:0] BALANCED_ONES = 4'h4;
   // -----------------------------------------------------------------
   // Serial port states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      DCZ_IDLE = 3'h1,
      DCZ_SHIFT = 3'h2,
      DCZ_WAIT_HIGH = 3'h4
   } dcz_state_type;
endpackage : dcz_pkg

// ---- dcz_zero_chan.sv ----
// Zero condition detector for one audio channel.
`timescale 1ns/1ps
`default_nettype none
module dcz_zero_chan
   import dcz_pkg::*;
#(
   parameter int WORD_COUNT = ZERO_WORDS,
   parameter int BS_CYCLES = BS_ZERO_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic word_tick,
   input wire logic data_tick,
   input wire logic data_bit,
   input wire logic bs_mode,
   input wire logic [1:0] dz_mode,
   output logic zero_ff
);
   typedef struct packed {
      logic [$clog2(WORD_COUNT+1)-1:0] words;
      logic word_nonzero;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic [$clog2(BS_CYCLES+1)-1:0] bs_time;
      logic bs_ok;
      logic zero;
   } dcz_chan_type;

   dcz_chan_type cur_ff, nxt;
   logic [3:0] ones;

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   // Word counting restarts on any high bit; pattern timing restarts on any bad byte.
   always_comb begin
      nxt = cur_ff;
      ones = 4'h0;
      for (int i = 0; i < 8; i++) begin
         ones = ones + {3'h0, cur_ff.shreg[i]};
      end
      if (data_tick) begin
         if (data_bit) begin
            nxt.word_nonzero = 1'b1;
         end
         nxt.shreg = {cur_ff.shreg[6:0], data_bit};
         nxt.bitcnt = cur_ff.bitcnt + 3'h1;
      end
      if (word_tick) begin
         if (cur_ff.word_nonzero || (data_tick && data_bit)) begin
            nxt.words = '0;
         end else if (cur_ff.words != WORD_COUNT[$bits(cur_ff.words)-1:0]) begin
            nxt.words = cur_ff.words + 1'b1;
         end
         nxt.word_nonzero = 1'b0;
      end
      // A whole byte has landed when the bit counter wraps.
      if (data_tick && cur_ff.bitcnt == 3'h7) begin
         if (dz_mode == DZ_BALANCED) begin
            nxt.bs_ok = (ones - {3'h0, cur_ff.shreg[7]} + {3'h0, data_bit}) == BALANCED_ONES;
         end else begin
            nxt.bs_ok = {cur_ff.shreg[6:0], data_bit} == FIXED_PATTERN;
         end
      end
      if (!cur_ff.bs_ok) begin
         nxt.bs_time = '0;
      end else if (cur_ff.bs_time != BS_CYCLES[$bits(cur_ff.bs_time)-1:0]) begin
         nxt.bs_time = cur_ff.bs_time + 1'b1;
      end
      if (bs_mode) begin
         nxt.zero = (dz_mode == DZ_BALANCED || dz_mode == DZ_FIXED) &&
                    cur_ff.bs_time == BS_CYCLES[$bits(cur_ff.bs_time)-1:0];
      end else begin
         nxt.zero = cur_ff.words == WORD_COUNT[$bits(cur_ff.words)-1:0];
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt;
      end
   end

   assign zero_ff = cur_ff.zero;
endmodule : dcz_zero_chan
`default_nettype wire

// ---- dcz_ctrl_port_properties.sv ----
// Checker of the control port and zero flag pins, seen from the top ports.
`timescale 1ns/1ps
`default_nettype none
module dcz_ctrl_port_checker
   import dcz_pkg::*;
#(
   parameter logic [4:0] PART_ID = 5'h01, // Arbitrary value.
   parameter int WORD_COUNT = ZERO_WORDS,
   parameter int BS_CYCLES = BS_ZERO_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ctrl_bit_clock,
   input wire logic ctrl_select_n,
   input wire logic ctrl_serial_in,
   input wire logic lr_word_clock,
   input wire logic audio_bit_clock,
   input wire logic left_data_in,
   input wire logic right_data_in,
   input wire logic left_zero_flag_pin,
   input wire logic right_zero_flag_pin,
   input wire logic [7:0] left_atten_level,
   input wire logic [7:0] right_atten_level,
   input wire logic [7:0] format_ctrl,
   input wire logic [7:0] output_ctrl,
   input wire logic [7:0] mode_ctrl,
   input wire logic [7:0] zero_ctrl
);
   // -----------------------------------------------------------------
   // Sequences of the port being left alone
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence sel_idle;
      ctrl_select_n [*6];
   endsequence
   sequence sel_long_idle;
      ctrl_select_n [*8];
   endsequence
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   // Registers move only at the end of a word, while select is still low.
   a_regs_need_write: assert property (
      !$stable({output_ctrl, mode_ctrl, zero_ctrl, format_ctrl}) |-> !$past(ctrl_select_n, 2))
      else $error("control register changed outside a word");
   a_atten_need_write: assert property (
      !$stable({left_atten_level, right_atten_level}) |-> !$past(ctrl_select_n, 2))
      else $error("attenuation changed outside a word");
   a_atten_hold_off: assert property (
      !format_ctrl[ATTEN_LOAD_ENABLE_BIT] && !$past(format_ctrl[ATTEN_LOAD_ENABLE_BIT])
      |-> $stable({left_atten_level, right_atten_level}))
      else $error("attenuation moved while load disabled");
   a_regs_idle_quiet: assert property (
      sel_idle |-> $stable({output_ctrl, mode_ctrl, zero_ctrl, format_ctrl}))
      else $error("register changed while port idle");
   a_readback_idle_low: assert property (
      sel_long_idle ##0 output_ctrl[READBACK_OUTPUT_ENABLE_BIT] |-> !left_zero_flag_pin)
      else $error("read data pin high while port idle");
   a_read_ends_low: assert property (
      $rose(ctrl_select_n) ##0 output_ctrl[READBACK_OUTPUT_ENABLE_BIT] |-> ##[1:6] !left_zero_flag_pin)
      else $error("read data pin not released after word");
   a_flags_off_low: assert property (
      (!zero_ctrl[PCM_ZERO_OUT_ENABLE_BIT] && !mode_ctrl[BSM_BIT] && !output_ctrl[READBACK_OUTPUT_ENABLE_BIT]) [*2]
      |-> !left_zero_flag_pin && !right_zero_flag_pin)
      else $error("zero flag shown while disabled");
   a_reset_values: assert property (
      $rose(arst_n) |-> left_atten_level == RST_LEFT_ATTEN && format_ctrl == RST_FORMAT_CTRL
      && zero_ctrl == RST_ZERO_CTRL && !left_zero_flag_pin)
      else $error("wrong values after reset");
endmodule : dcz_ctrl_port_checker
`default_nettype wire

// ---- dcz_host_model.sv ----
// Host controller model that drives the serial control port.
`timescale 1ns/1ps
`default_nettype none
module dcz_host_model (
   input wire logic clk,
   output logic ctrl_bit_clock,
   output logic ctrl_select_n,
   output logic ctrl_serial_in,
   input wire logic left_zero_flag_pin
);
   // The bit clock stands low and select high between words.
   initial begin
      ctrl_bit_clock = 1'b0;
      ctrl_select_n = 1'b1;
      ctrl_serial_in = 1'b0;
   end
   // Sends nbits of a word MSB first at 160 ns a bit; fewer than 16 aborts it.
   // Read bits are taken mid high phase, clear of the shift that each fall starts.
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      ctrl_select_n <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         ctrl_serial_in <= w[i];
         repeat (4) @(posedge clk);
         ctrl_bit_clock <= 1'b1;
         repeat (2) @(posedge clk);
         if (i < 8) begin
            rd[i] = left_zero_flag_pin;
         end
         repeat (2) @(posedge clk);
         ctrl_bit_clock <= 1'b0;
      end
      repeat (4) @(posedge clk);
      ctrl_select_n <= 1'b1;
      ctrl_serial_in <= ~ctrl_serial_in;
      repeat (4) @(posedge clk);
   endtask : xfer
endmodule : dcz_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the serial control port and zero flag pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dcz_pkg::*;
   localparam logic [4:0] TB_PART_ID = 5'h0A; // Arbitrary value.
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic lr_word_clock = 1'b0;
   logic audio_bit_clock = 1'b0;
   logic left_data_in = 1'b0;
   logic right_data_in = 1'b0;
   wire logic ctrl_bit_clock, ctrl_select_n, ctrl_serial_in;
   wire logic left_zero_flag_pin, right_zero_flag_pin;
   wire logic [7:0] left_atten_level, right_atten_level, format_ctrl;
   wire logic [7:0] output_ctrl, mode_ctrl, zero_ctrl;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] rd_val;
   logic [7:0] tbl [6];
   // Short counts keep the zero detect runs brief.
   dcz_ctrl_port #(.PART_ID(TB_PART_ID), .WORD_COUNT(8), .BS_CYCLES(50)) i_dut (
      .clk(clk), .arst_n(arst_n), .ctrl_bit_clock(ctrl_bit_clock),
      .ctrl_select_n(ctrl_select_n), .ctrl_serial_in(ctrl_serial_in),
      .lr_word_clock(lr_word_clock), .audio_bit_clock(audio_bit_clock),
      .left_data_in(left_data_in), .right_data_in(right_data_in),
      .left_zero_flag_pin(left_zero_flag_pin), .right_zero_flag_pin(right_zero_flag_pin),
      .left_atten_level(left_atten_level), .right_atten_level(right_atten_level),
      .format_ctrl(format_ctrl), .output_ctrl(output_ctrl), .mode_ctrl(mode_ctrl),
      .zero_ctrl(zero_ctrl));
   dcz_host_model i_host (.clk(clk), .ctrl_bit_clock(ctrl_bit_clock),
      .ctrl_select_n(ctrl_select_n), .ctrl_serial_in(ctrl_serial_in),
      .left_zero_flag_pin(left_zero_flag_pin));
   // Clock and a ceiling on the run, so a hang still ends in a verdict.
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      i_host.xfer({1'b0, idx, d}, 16, rd_val);
   endtask : wr
   task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
      i_host.xfer({1'b1, idx, 8'h00}, 16, rd_val);
      check($sformatf("reg %h", idx), rd_val, exp);
   endtask : rdc
   task automatic rd_all();
      for (int k = 0; k < 6; k++) begin
         rdc(IDX_LEFT_ATTEN + 7'(k), tbl[k]);
      end
   endtask : rd_all
   // Whole bytes only, so stream byte alignment never slips.
   task automatic feed(input logic [7:0] lb, input logic [7:0] rb, input int n, input logic w);
      repeat (n) begin
         for (int i = 7; i >= 0; i--) begin
            left_data_in <= lb[i];
            right_data_in <= rb[i];
            lr_word_clock <= w && i > 3;
            repeat (2) @(posedge clk);
            audio_bit_clock <= 1'b1;
            repeat (2) @(posedge clk);
            audio_bit_clock <= 1'b0;
         end
      end
      repeat (8) @(posedge clk);
   endtask : feed
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("format_ctrl", format_ctrl, RST_FORMAT_CTRL);
      wr(IDX_OUTPUT_CTRL, 8'h08);
      check("output_ctrl", output_ctrl, 8'h08);
      tbl = '{RST_LEFT_ATTEN, RST_RIGHT_ATTEN, RST_FORMAT_CTRL, 8'h08, RST_MODE_CTRL, RST_ZERO_CTRL};
      rd_all();
      rdc(IDX_PART_ID, {3'h0, TB_PART_ID});
      rdc(IDX_ZERO_STATUS, 8'h00);
      rdc(7'h20, 8'h00);
      $display("Test reset values done");
      tbl = '{8'h40, 8'h33, 8'h3E, 8'hC9, 8'h1F, 8'h07};
      for (int k = 0; k < 6; k++) begin
         wr(IDX_LEFT_ATTEN + 7'(k), tbl[k]);
      end
      rd_all();
      check("left_atten", left_atten_level, RST_LEFT_ATTEN);
      wr(IDX_ZERO_STATUS, 8'hFF);
      wr(IDX_PART_ID, 8'hFF);
      wr(7'h00, 8'h77);
      i_host.xfer({1'b0, IDX_LEFT_ATTEN, 8'h11}, 10, rd_val);
      rd_all();
      rdc(IDX_PART_ID, {3'h0, TB_PART_ID});
      wr(IDX_FORMAT_CTRL, 8'hBE);
      check("left_atten", left_atten_level, 8'h40);
      check("right_atten", right_atten_level, 8'h33);
      wr(IDX_MODE_CTRL, 8'h00);
      wr(IDX_ZERO_CTRL, 8'h01);
      wr(IDX_OUTPUT_CTRL, 8'h08);
      $display("Test register access done");
      feed(8'h00, 8'h00, 10, 1'b1);
      check("right pin and", {7'h0, right_zero_flag_pin}, 8'h01);
      rdc(IDX_ZERO_STATUS, 8'h03);
      feed(8'hFF, 8'h00, 2, 1'b1);
      check("right pin and", {7'h0, right_zero_flag_pin}, 8'h00);
      wr(IDX_OUTPUT_CTRL, 8'h00);
      check("left pin", {7'h0, left_zero_flag_pin}, 8'h00);
      check("right pin", {7'h0, right_zero_flag_pin}, 8'h01);
      wr(IDX_ZERO_CTRL, 8'h00);
      check("right pin", {7'h0, right_zero_flag_pin}, 8'h00);
      $display("Test pcm zero done");
      wr(IDX_MODE_CTRL, 8'h20);
      wr(IDX_ZERO_CTRL, 8'h02);
      feed(8'hFF, 8'hFF, 6, 1'b0);
      check("left pin", {7'h0, left_zero_flag_pin}, 8'h00);
      feed(8'h0F, 8'hF0, 6, 1'b0);
      check("left pin", {7'h0, left_zero_flag_pin}, 8'h01);
      check("right pin", {7'h0, right_zero_flag_pin}, 8'h01);
      wr(IDX_ZERO_CTRL, 8'h04);
      feed(8'h0F, 8'h0F, 6, 1'b0);
      check("left pin", {7'h0, left_zero_flag_pin}, 8'h00);
      feed(FIXED_PATTERN, FIXED_PATTERN, 6, 1'b0);
      check("left pin", {7'h0, left_zero_flag_pin}, 8'h01);
      check("right pin", {7'h0, right_zero_flag_pin}, 8'h01);
      $display("Test stream zero done");
      wr(IDX_MODE_CTRL, 8'h40);
      check("format_ctrl", format_ctrl, RST_FORMAT_CTRL);
      check("zero_ctrl", zero_ctrl, RST_ZERO_CTRL);
      check("mode_ctrl", mode_ctrl, RST_MODE_CTRL);
      $display("Test soft reset done");
      stop_test();
   end
endmodule : tb_top
bind dcz_ctrl_port dcz_ctrl_port_checker #(.PART_ID(PART_ID), .WORD_COUNT(WORD_COUNT),
   .BS_CYCLES(BS_CYCLES)) i_chk (.clk(clk), .arst_n(arst_n),
   .ctrl_bit_clock(ctrl_bit_clock), .ctrl_select_n(ctrl_select_n),
   .ctrl_serial_in(ctrl_serial_in), .lr_word_clock(lr_word_clock),
   .audio_bit_clock(audio_bit_clock), .left_data_in(left_data_in),
   .right_data_in(right_data_in), .left_zero_flag_pin(left_zero_flag_pin),
   .right_zero_flag_pin(right_zero_flag_pin), .left_atten_level(left_atten_level),
   .right_atten_level(right_atten_level), .format_ctrl(format_ctrl),
   .output_ctrl(output_ctrl), .mode_ctrl(mode_ctrl), .zero_ctrl(zero_ctrl));
`default_nettype wire
